// file: rtl/sac_pkg.sv
// Purpose: shared constants and types for the sar converter control block
// Assumes: axi4-lite with 32-bit data, one register per aligned word
// Notes:   offsets are indices; byte address is four times the index
package sac_pkg;
  // register indices and byte addresses
  localparam logic [7:0]  IDX_CTRL1    = 8'h1c;
  localparam logic [7:0]  IDX_CTRL2    = 8'h1d;
  localparam logic [7:0]  IDX_RES_LOW  = 8'h1e;
  localparam logic [7:0]  IDX_RES_UP   = 8'h1f;
  localparam logic [11:0] ADDR_CTRL1   = {2'h0, IDX_CTRL1, 2'h0};
  localparam logic [11:0] ADDR_CTRL2   = {2'h0, IDX_CTRL2, 2'h0};
  localparam logic [11:0] ADDR_RES_LOW = {2'h0, IDX_RES_LOW, 2'h0};
  localparam logic [11:0] ADDR_RES_UP  = {2'h0, IDX_RES_UP, 2'h0};
  localparam logic [11:0] ADDR_POWER   = 12'h080;  // low-power mode input mirror
  // reset values
  localparam logic [7:0]  CTRL1_RST    = 8'h10;
  localparam logic [5:0]  CTRL2_RST    = 6'h10;    // bits 5..0 stored
  // field positions
  localparam int          START_BIT    = 7;
  localparam int          DISABLE_BIT  = 4;
  localparam int          LADDER_BIT   = 5;
  localparam int          RES_W        = 10;
  // mode codes
  localparam logic [1:0]  MODE_OFF     = 2'h0;
  localparam logic [1:0]  MODE_SINGLE  = 2'h1;
  localparam logic [1:0]  MODE_REPEAT  = 2'h3;
  // conversion lengths in fc periods
  localparam logic [10:0] CNV_39   = 11'h027;
  localparam logic [10:0] CNV_78   = 11'h04e;
  localparam logic [10:0] CNV_156  = 11'h09c;
  localparam logic [10:0] CNV_312  = 11'h138;
  localparam logic [10:0] CNV_624  = 11'h270;
  localparam logic [10:0] CNV_1248 = 11'h4e0;
  // axi response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // control register one layout
  typedef struct packed {
    logic       start;
    logic [1:0] mode;
    logic       ain_dis;
    logic [3:0] chan;
  } sac_ctrl1_t;

  // front end handshake towards the comparator
  typedef struct packed {
    logic        ladder_on;
    logic        ain_dis;
    logic [3:0]  chan;
    logic [9:0]  trial;
  } sac_fe_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } sac_state_t;
endpackage

// file: rtl/sac_ctrl.sv
// Purpose: sar converter control registers and conversion sequencer
// Assumes: axi4-lite slave, comparator result is synchronised here
// Notes:   one conversion spans the coded fc count split over ten bit trials
//
// Design decision made here: register access over AXI4-Lite.
module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          low_power,     // stop, slow or sleep active
  input  wire logic          cmp_hi,        // comparator: input above trial level
  output sac_fe_t            fe,            // front end controls
  output logic               conversion_complete_irq,
  input  wire logic [11:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [11:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  // whole conversion length from the conversion-time code
  function automatic logic [10:0] cnv_len(input logic [2:0] code);
    case (code)
      3'h0:    cnv_len = CNV_39;
      3'h2:    cnv_len = CNV_78;
      3'h3:    cnv_len = CNV_156;
      3'h4:    cnv_len = CNV_312;
      3'h5:    cnv_len = CNV_624;
      3'h6:    cnv_len = CNV_1248;
      default: cnv_len = CNV_39;  // reserved codes fall back to shortest
    endcase
  endfunction

  // pin synchronisers
  logic [1:0]   lp_sync_q;       // low-power level
  logic [1:0]   cmp_sync_q;      // comparator level
  logic         lp;              // synchronised low-power
  logic         cmp;             // synchronised comparator

  // registers
  sac_ctrl1_t   ctrl1_q, ctrl1_d;       // start, mode, input control, channel
  logic [5:0]   ctrl2_q, ctrl2_d;       // ladder, bit4 (writable, reset 1), time code, bit0
  logic [9:0]   result_q, result_d;     // stored conversion result
  logic         done_q, done_d;         // conversion done flag
  logic         irq_q, irq_d;           // completion pulse
  sac_state_t   st_q, st_d;             // sequencer state
  logic [9:0]   sar_q, sar_d;           // approximation register
  logic [9:0]   bit_q, bit_d;           // bit under trial, one-hot
  logic [10:0]  cnt_q, cnt_d;           // fc cycles left in conversion
  logic [10:0]  step_q, step_d;         // cycles left in current trial
  logic [10:0]  step_len;               // cycles per bit trial

  // bus state
  logic         aw_hold_q, aw_hold_d;   // write address captured
  logic         w_hold_q, w_hold_d;     // write data captured
  logic [11:0]  awaddr_q, awaddr_d;
  logic [31:0]  wdata_q, wdata_d;
  logic [3:0]   wstrb_q, wstrb_d;
  logic         bvalid_q, bvalid_d;
  logic [1:0]   bresp_q, bresp_d;
  logic         rvalid_q, rvalid_d;
  logic [31:0]  rdata_q, rdata_d;
  logic [1:0]   rresp_q, rresp_d;
  logic         wr_go;                  // write performed this cycle
  logic         rd_go;                  // read performed this cycle
  logic         busy;                   // conversion in progress

  assign lp       = lp_sync_q[1];
  assign cmp      = cmp_sync_q[1];
  assign busy     = (st_q == ST_CONV);
  assign step_len = cnv_len(ctrl2_q[3:1]) / 11'd10;
  assign wr_go    = aw_hold_q && w_hold_q && !bvalid_q;
  assign rd_go    = s_axi_arvalid && !rvalid_q;

  // synchronisers: first stage read only by second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lp_sync_q  <= 2'h0;
      cmp_sync_q <= 2'h0;
    end else begin
      lp_sync_q  <= {lp_sync_q[0], low_power};
      cmp_sync_q <= {cmp_sync_q[0], cmp_hi};
    end
  end

  // axi handshake next state
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    // address and data accepted in either order
    if (s_axi_awvalid && !aw_hold_q) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_q) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      // only the two control registers answer okay; all other addresses answer slverr
      bresp_d   = (awaddr_q == ADDR_CTRL1 || awaddr_q == ADDR_CTRL2) ? RESP_OKAY
                                                                     : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL1:   rdata_d = {24'h0, ctrl1_q};
        // top two bits are undefined; this build returns zero
        ADDR_CTRL2:   rdata_d = {24'h0, 2'h0, ctrl2_q};
        ADDR_RES_LOW: rdata_d = {24'h0, result_q[1:0], done_q, busy, 4'h0};
        ADDR_RES_UP:  rdata_d = {24'h0, result_q[9:2]};
        ADDR_POWER:   rdata_d = {31'h0, lp};
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 12'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // control registers and sequencer next state
  always_comb begin
    ctrl1_d  = ctrl1_q;
    ctrl2_d  = ctrl2_q;
    result_d = result_q;
    done_d   = done_q;
    irq_d    = 1'b0;
    st_d     = st_q;
    sar_d    = sar_q;
    bit_d    = bit_q;
    cnt_d    = cnt_q;
    step_d   = step_q;
    // software writes, byte lane zero only
    if (wr_go && wstrb_q[0]) begin
      if (awaddr_q == ADDR_CTRL1) begin
        ctrl1_d = sac_ctrl1_t'(wdata_q[7:0]);
      end
      if (awaddr_q == ADDR_CTRL2) begin
        ctrl2_d = wdata_q[5:0];
      end
    end
    // reading the upper result clears done
    if (rd_go && s_axi_araddr == ADDR_RES_UP) begin
      done_d = 1'b0;
    end
    case (st_q)
      ST_IDLE: begin
        // start only honoured in single or repeat mode
        if (ctrl1_q.start &&
            (ctrl1_q.mode == MODE_SINGLE || ctrl1_q.mode == MODE_REPEAT)) begin
          st_d  = ST_CONV;
          sar_d = 10'h200;
          bit_d = 10'h200;
          cnt_d = cnv_len(ctrl2_q[3:1]);
          step_d = step_len;
          ctrl1_d.start = 1'b0;
        end
      end
      ST_CONV: begin
        cnt_d  = cnt_q - 11'd1;
        step_d = step_q - 11'd1;
        // one bit decided per trial, msb first
        if (step_q <= 11'd1 && bit_q != 10'h0) begin
          sar_d  = (cmp ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
          bit_d  = bit_q >> 1;
          step_d = step_len;
        end
        if (cnt_q <= 11'd1) begin
          st_d = ST_DONE;
        end
        if (ctrl1_q.mode == MODE_OFF) begin
          st_d = ST_IDLE;
        end
      end
      ST_DONE: begin
        result_d = sar_q;
        done_d   = 1'b1;
        irq_d    = 1'b1;
        if (ctrl1_q.mode == MODE_REPEAT) begin
          st_d   = ST_CONV;
          sar_d  = 10'h200;
          bit_d  = 10'h200;
          cnt_d  = cnv_len(ctrl2_q[3:1]);
          step_d = step_len;
        end else begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // standby: registers reinitialised, writes refused, conversion dropped
    if (lp) begin
      ctrl1_d  = sac_ctrl1_t'(CTRL1_RST);
      ctrl2_d  = CTRL2_RST;
      st_d     = ST_IDLE;
      result_d = 10'h0;
      done_d   = 1'b0;
      irq_d    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_q  <= sac_ctrl1_t'(CTRL1_RST);
      ctrl2_q  <= CTRL2_RST;
      result_q <= 10'h0;
      done_q   <= 1'b0;
      irq_q    <= 1'b0;
      st_q     <= ST_IDLE;
      sar_q    <= 10'h0;
      bit_q    <= 10'h0;
      cnt_q    <= 11'h0;
      step_q   <= 11'h0;
    end else begin
      ctrl1_q  <= ctrl1_d;
      ctrl2_q  <= ctrl2_d;
      result_q <= result_d;
      done_q   <= done_d;
      irq_q    <= irq_d;
      st_q     <= st_d;
      sar_q    <= sar_d;
      bit_q    <= bit_d;
      cnt_q    <= cnt_d;
      step_q   <= step_d;
    end
  end

  // outputs
  assign fe.ladder_on = ctrl2_q[LADDER_BIT] || busy;
  assign fe.ain_dis   = ctrl1_q.ain_dis;
  assign fe.chan      = ctrl1_q.chan;
  assign fe.trial     = sar_q;
  assign conversion_complete_irq = irq_q;
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule

// file: tb/sac_chk.sv
// Purpose: port checker for the sar control block
// Assumes: aw and w offered together by the master
// Notes:   standby counts once low_power stood three samples
module sac_chk
  import sac_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        low_power,
  input wire sac_fe_t     fe,
  input wire logic        conversion_complete_irq,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [1:0]  lp_q, lp_d;   // low_power history
  logic [11:0] cnt_q, cnt_d; // cycles with ladder on
  logic        wr1, lp3, lp0; // ctrl1 write, standby, awake
  assign wr1 = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
               && s_axi_awaddr == ADDR_CTRL1 && s_axi_wstrb[0];
  assign lp3 = &{lp_q, low_power};
  assign lp0 = ~|{lp_q, low_power};
  // saturating count, so ladder-always-on runs never wrap
  always_comb begin
    lp_d  = {lp_q[0], low_power};
    cnt_d = fe.ladder_on ? cnt_q + {11'h0, ~&cnt_q} : 12'h0;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lp_q  <= 2'h0;
      cnt_q <= 12'h0;
    end else begin
      lp_q  <= lp_d;
      cnt_q <= cnt_d;
    end
  end
  // a write taken at one edge lands in the register at the next, so look two edges on
  AST_CHAN: assert property (wr1 && lp0 |-> ##2 fe.chan == $past(s_axi_wdata[3:0], 2))
    else $error("channel not taken");
  AST_AIN: assert property (wr1 && lp0 |-> ##2 fe.ain_dis == $past(s_axi_wdata[4], 2))
    else $error("input disable not taken");
  AST_LP_WRITE: assert property (wr1 && lp3 |-> ##2 fe.chan == 4'h0 && fe.ain_dis)
    else $error("write accepted in standby");
  AST_LP_LADDER: assert property (lp3 |=> !fe.ladder_on)
    else $error("ladder on in standby");
  // write lands one edge after the handshake, the sequencer leaves idle one edge later
  AST_START: assert property (wr1 && lp0 && s_axi_wdata[7] && s_axi_wdata[5] &&
    !fe.ladder_on |-> ##3 fe.ladder_on) else $error("start ignored");
  AST_ABORT: assert property (wr1 && lp0 && s_axi_wdata[6:5] == 2'h0 |=>
    !conversion_complete_irq [*8]) else $error("completion after abort");
  AST_IRQ_PULSE: assert property (conversion_complete_irq |=> !conversion_complete_irq)
    else $error("irq longer than a cycle");
  // the completion cycle itself drops the ladder, so judge the count one cycle back
  AST_MIN_CONV: assert property (conversion_complete_irq |-> $past(cnt_q) >= 12'h027)
    else $error("conversion too short");
  COV_REP: cover property (conversion_complete_irq ##[38:45] conversion_complete_irq);
  COV_LPW: cover property (wr1 && lp3);
  COV_RST: cover property (wr1 && s_axi_wdata[7] && s_axi_wdata[6:5] == 2'h3);
endmodule

bind sac_ctrl sac_chk u_chk (.core_clk(core_clk), .nrst(nrst), .low_power(low_power),
  .fe(fe), .conversion_complete_irq(conversion_complete_irq),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready));

// file: tb/sac_fe_model.sv
// Purpose: comparator front end model
// Assumes: fixed level per input, ideal comparator
// Notes:   disabled inputs read as ground
module sac_fe_model
  import sac_pkg::*;
(
  input  wire sac_fe_t fe,
  output logic         cmp_hi
);
  logic [9:0] level; // routed input level
  // distinct level per channel so a misroute shows
  assign level  = fe.ain_dis ? 10'h000 : {fe.chan, 6'h25};
  assign cmp_hi = level >= fe.trial;
endmodule

// file: tb/sac_ctrl_test.sv
// Purpose: self-checking bench for the sar control block
// Assumes: front end model answers at once
// Notes:   reserved time codes run as the shortest
module sac_ctrl_test
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, nrst = 1'b0, low_power = 1'b0, cmp_hi, irq;
  sac_fe_t     fe;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  int          fail_count = 0, n_compared = 0, cyc = 0, t0, t1;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  sac_ctrl dut (.core_clk(core_clk), .nrst(nrst), .low_power(low_power), .cmp_hi(cmp_hi),
    .fe(fe), .conversion_complete_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sac_fe_model u_fe (.fe(fe), .cmp_hi(cmp_hi));
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // each channel released at its own ready edge
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(RESP_OKAY));
  endtask
  task rd(input logic [11:0] a);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    rsp = rresp;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] m, e);
    rd(a);
    chk(d & m, e);
  endtask
  task wirq;
    do @(posedge core_clk); while (irq !== 1'b1);
    t1 = cyc;
  endtask
  function automatic int clen(input logic [2:0] c);
    case (c)
      3'h2: return 78;
      3'h3: return 156;
      3'h4: return 312;
      3'h5: return 624;
      3'h6: return 1248;
      default: return 39;
    endcase
  endfunction
  task t_reset;
    rc(ADDR_CTRL1, 32'hff, 32'h10);
    rc(ADDR_CTRL2, 32'h3f, 32'h10);
    rd(12'h0fc);
    chk(32'(rsp), 32'(RESP_SLVERR));
  endtask
  // every time code and every channel, last one with inputs off
  task t_single;
    logic [9:0] lv;
    for (int i = 0; i < 16; i++) begin
      lv = (i == 15) ? 10'h000 : {i[3:0], 6'h25};
      wr(ADDR_CTRL2, {4'h1, i[2:0], 1'b0});
      chk(32'(fe.ladder_on), 32'h0);
      wr(ADDR_CTRL1, {3'h5, i == 15, i[3:0]});
      t0 = cyc;
      chk(32'(fe.chan), 32'(i[3:0]));
      chk(32'(fe.ain_dis), 32'(i == 15));
      rc(ADDR_CTRL1, 32'h80, 32'h0);
      rc(ADDR_RES_LOW, 32'h10, 32'h10);
      wirq;
      chk(32'(t1 - t0 >= clen(i[2:0]) - 1 && t1 - t0 <= clen(i[2:0]) + 3), 32'h1);
      rc(ADDR_RES_LOW, 32'hf0, {24'h0, lv[1:0], 6'h20});
      rc(ADDR_RES_UP, 32'hff, {24'h0, lv[9:2]});
      rc(ADDR_RES_LOW, 32'h20, 32'h0);
    end
  endtask
  task t_modes;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL1, {1'b1, k[0], 6'h00});
      repeat (50) @(posedge core_clk);
      rc(ADDR_RES_LOW, 32'h30, 32'h0);
    end
  endtask
  task t_repeat;
    int n;
    n = 0;
    wr(ADDR_CTRL2, 8'h10);
    wr(ADDR_CTRL1, 8'he3);
    wirq;
    t0 = t1;
    wirq;
    chk(32'(t1 - t0 >= 38 && t1 - t0 <= 44), 32'h1);
    wr(ADDR_CTRL1, 8'h03);
    repeat (100) begin
      @(posedge core_clk);
      n += int'(irq === 1'b1);
    end
    chk(32'(n), 32'h0);
    rc(ADDR_RES_LOW, 32'h10, 32'h0);
  endtask
  // standby mid-conversion with the ladder held on
  task t_lp;
    wr(ADDR_CTRL2, 8'h3a);
    chk(32'(fe.ladder_on), 32'h1);
    wr(ADDR_CTRL1, 8'ha5);
    low_power <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(32'(fe.ladder_on), 32'h0);
    chk(32'(fe.ain_dis), 32'h1);
    rc(ADDR_POWER, 32'h1, 32'h1);
    wr(ADDR_CTRL1, 8'h07);
    rc(ADDR_CTRL1, 32'hff, 32'h10);
    wr(ADDR_CTRL2, 8'h3e);
    rc(ADDR_CTRL2, 32'h3f, 32'h10);
    rc(ADDR_RES_LOW, 32'h30, 32'h0);
    low_power <= 1'b0;
    repeat (5) @(posedge core_clk);
    rc(ADDR_POWER, 32'h1, 32'h0);
    wr(ADDR_CTRL1, 8'h07);
    rc(ADDR_CTRL1, 32'hff, 32'h07);
  endtask
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (15000) @(posedge core_clk);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset;
    t_single;
    t_modes;
    t_repeat;
    t_lp;
    stop_test;
  end
endmodule
